//--- hdl/tlbma_top.sv
// Operation
// - Miss or store fault loads the faulting effective address into the miss address.
// - Software reads and writes the miss address by register moves.
// - Fault loads miss status, laid out like the data fault status register.
// - Compare word bit 0 always reads one.
// - Compare bits 1-24 give segment id chosen by miss address bits 0-3.
// - Compare bit 25 always reads zero, the primary hash.
// - Compare bits 26-31 give miss address bits 4-9.
// - Compare word is read-only; a write is an invalid instruction.
// - Group address registers give primary and secondary hash group addresses.
// - Hash fields follow current miss address, table base and segment at read.
// - Writing either group address register is an invalid instruction.
// - Fill data is a lower entry word, fields coded as in the table.
// - Fill tag comes from the compare word and the selected segment.
// - A fill write updates the least recently used way of the set.
// - Reading either fill register is an invalid instruction.
// - Recent-fault entry accesses the way named by miss status bits 7-8.
// - Recent-fault entry exposes the selected entry lower word, read and write.
// - Target entry follows register contents at access time, not fault time.
`timescale 1ns/1ps
module tlbma_top
  import tlbma_pkg::*;
(
  input wire logic sys_clk,                       // 10 MHz core clock
  input wire logic rst_n,                         // Synchronous reset, active low
  input wire logic spr_req_valid,                 // Register move request
  input wire logic spr_req_write,                 // 1 move-to, 0 move-from
  input wire logic [9:0] spr_req_num,             // Register number
  input wire logic [31:0] spr_req_wdata,          // Move-to data
  output logic spr_ack,                           // Answer for one of ours
  output logic [31:0] spr_rdata,                  // Move-from data
  output logic spr_illegal,                       // Invalid access, to exceptions
  input wire logic fault_valid,                   // Miss or store fault taken
  input wire logic [31:0] fault_ea,               // Faulting effective address
  input wire logic [31:0] fault_status,           // Fault description word
  output logic [3:0] seg_index,                   // Segment register selector
  input wire logic [23:0] seg_virtual_segment_id,               // Selected segment id
  input wire logic [31:0] table_base_reg,         // Table base register value
  input wire logic touch_valid,                   // Translation hit
  input wire logic [TLBMA_SET_BITS-1:0] touch_set, // Hit set
  input wire logic [1:0] touch_way,               // Hit way
  output logic lk_valid,                          // Looked-up entry valid
  output logic [30:0] lk_tag,                     // Looked-up entry tag
  output logic [31:0] lk_data                     // Looked-up entry lower word
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] miss_address_reg;
  logic [31:0] miss_address_next;
  logic [31:0] miss_status_reg;
  logic [31:0] miss_status_next;
  logic [31:0] cmp_word;
  logic [31:0] pri_addr;
  logic [31:0] sec_addr;
  logic [31:0] mrf_rdata;
  logic [1:0] lru_way;
  logic [1:0] mrf_way;
  logic [TLBMA_SET_BITS-1:0] set_idx;
  logic sel_mar, sel_miss_status_reg, sel_cmp, sel_pri, sel_sec, sel_fa, sel_fb, sel_mrf;
  logic ours;
  logic bad_access;
  logic rd_ok;
  logic we_mar, we_miss_status_reg, we_fa, we_fb, we_mrf;
  tlbma_acc_t acc_reg;
  tlbma_acc_t acc_next;
  logic [31:0] spr_rdata_reg;
  logic [31:0] spr_rdata_next;

  // ----------------------------------------------------------------
  // Register number decode
  // ----------------------------------------------------------------
  // One-hot selects, used by the write strobes and the read mux
  always_comb begin
    sel_mar = 1'b0;
    sel_miss_status_reg = 1'b0;
    sel_cmp = 1'b0;
    sel_pri = 1'b0;
    sel_sec = 1'b0;
    sel_fa = 1'b0;
    sel_fb = 1'b0;
    sel_mrf = 1'b0;
    if (spr_req_num == TLBMA_SPR_MISS_ADDR) begin
      sel_mar = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_MISS_STAT) begin
      sel_miss_status_reg = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_CMP) begin
      sel_cmp = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_HASH_PRI) begin
      sel_pri = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_HASH_SEC) begin
      sel_sec = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_FILL_A) begin
      sel_fa = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_FILL_B) begin
      sel_fb = 1'b1;
    end else if (spr_req_num == TLBMA_SPR_MRF) begin
      sel_mrf = 1'b1;
    end
  end

  assign ours = spr_req_valid && (sel_mar || sel_miss_status_reg || sel_cmp || sel_pri || sel_sec
                                  || sel_fa || sel_fb || sel_mrf);

  // Direction checks: read-only words refuse writes, fill words refuse reads
  assign bad_access = ours && ((spr_req_write && (sel_cmp || sel_pri || sel_sec))
                               || (!spr_req_write && (sel_fa || sel_fb)));
  assign rd_ok = ours && !spr_req_write && !bad_access;

  // Write strobes; an invalid access never reaches any of them
  assign we_mar = ours && spr_req_write && sel_mar;
  assign we_miss_status_reg = ours && spr_req_write && sel_miss_status_reg;
  assign we_fa = ours && spr_req_write && sel_fa && !fault_valid;
  assign we_fb = ours && spr_req_write && sel_fb && !fault_valid;
  assign we_mrf = ours && spr_req_write && sel_mrf && !fault_valid;

  // ----------------------------------------------------------------
  // Miss address and miss status
  // ----------------------------------------------------------------
  // A fault in the same cycle as a move-to wins, since the handler runs after it
  always_comb begin
    miss_address_next = miss_address_reg;
    if (fault_valid) begin
      miss_address_next = fault_ea;
    end else if (we_mar) begin
      miss_address_next = spr_req_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      miss_address_reg <= TLBMA_MISS_ADDR_RST;
    end else begin
      miss_address_reg <= miss_address_next;
    end
  end

  // Status word is kept whole so the handler can copy it straight across
  always_comb begin
    miss_status_next = miss_status_reg;
    if (fault_valid) begin
      miss_status_next = fault_status;
    end else if (we_miss_status_reg) begin
      miss_status_next = spr_req_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      miss_status_reg <= TLBMA_MISS_STAT_RST;
    end else begin
      miss_status_reg <= miss_status_next;
    end
  end

  // ----------------------------------------------------------------
  // Live selectors: nothing is latched at fault time
  // ----------------------------------------------------------------
  // Changing the miss address or status moves every target at once
  assign seg_index = miss_address_reg[TLBMA_SEG_MSB:TLBMA_SEG_LSB];
  assign set_idx = miss_address_reg[TLBMA_SET_LSB +: TLBMA_SET_BITS];
  assign mrf_way = miss_status_reg[TLBMA_WAY_MSB:TLBMA_WAY_LSB];

  // ----------------------------------------------------------------
  // Compare word and group addresses
  // ----------------------------------------------------------------
  // Pure combinational, so a read always reflects the present inputs
  tlbma_hash u_hash (
    .miss_addr(miss_address_reg),
    .seg_virtual_segment_id(seg_virtual_segment_id),
    .table_base(table_base_reg),
    .cmp_word(cmp_word),
    .pri_addr(pri_addr),
    .sec_addr(sec_addr)
  );

  // ----------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------
  // Fill data is stored as given; the tag drops the constant hash-select bit
  tlbma_store u_store (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_idx(set_idx),
    .fill_we_a(we_fa),
    .fill_we_b(we_fb),
    .fill_data(spr_req_wdata),
    .fill_tag({cmp_word[31:7], cmp_word[5:0]}),
    .mrf_way(mrf_way),
    .mrf_we(we_mrf),
    .mrf_wdata(spr_req_wdata),
    .mrf_rdata(mrf_rdata),
    .lru_way(lru_way),
    .touch_valid(touch_valid),
    .touch_set(touch_set),
    .touch_way(touch_way),
    .lk_valid(lk_valid),
    .lk_tag(lk_tag),
    .lk_data(lk_data)
  );

  // ----------------------------------------------------------------
  // Answer path
  // ----------------------------------------------------------------
  // Read data is sampled at the request edge, so it shows the values of that cycle
  always_comb begin
    spr_rdata_next = 32'h0000_0000;
    if (rd_ok) begin
      if (sel_mar) begin
        spr_rdata_next = miss_address_reg;
      end else if (sel_miss_status_reg) begin
        spr_rdata_next = miss_status_reg;
      end else if (sel_cmp) begin
        spr_rdata_next = cmp_word;
      end else if (sel_pri) begin
        spr_rdata_next = pri_addr;
      end else if (sel_sec) begin
        spr_rdata_next = sec_addr;
      end else if (sel_mrf) begin
        spr_rdata_next = mrf_rdata;
      end
    end
  end

  // Access outcome for the answer cycle
  always_comb begin
    acc_next = TLBMA_ACC_IDLE;
    if (bad_access) begin
      acc_next = TLBMA_ACC_BAD;
    end else if (ours) begin
      acc_next = TLBMA_ACC_OK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_reg <= TLBMA_ACC_IDLE;
      spr_rdata_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
      spr_rdata_reg <= spr_rdata_next;
    end
  end

  // Handshake from the outcome state; data straight from its flop
  always_comb begin
    case (acc_reg)
      TLBMA_ACC_OK: begin
        spr_ack = 1'b1;
        spr_illegal = 1'b0;
      end
      TLBMA_ACC_BAD: begin
        spr_ack = 1'b1;
        spr_illegal = 1'b1;
      end
      default: begin
        spr_ack = 1'b0;
        spr_illegal = 1'b0;
      end
    endcase
  end
  assign spr_rdata = spr_rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_answer;
    ##1 (spr_ack && spr_illegal && spr_rdata == 32'h0000_0000);
  endsequence

  sequence s_good_answer;
    ##1 (spr_ack && !spr_illegal);
  endsequence

  AST_MAR_CAPTURE: assert property (
    fault_valid |=> (miss_address_reg == $past(fault_ea)))
    else $error("miss address did not capture the fault address");

  AST_MAR_MOVE: assert property (
    (spr_req_valid && spr_req_write && spr_req_num == TLBMA_SPR_MISS_ADDR && !fault_valid)
    ##1 (spr_req_valid && !spr_req_write && spr_req_num == TLBMA_SPR_MISS_ADDR && !fault_valid)
    |=> (spr_ack && spr_rdata == $past(spr_req_wdata, 2)))
    else $error("miss address write did not read back");

  AST_MISS_STATUS_REG_CAPTURE: assert property (
    fault_valid |=> (miss_status_reg == $past(fault_status)))
    else $error("miss status did not capture the fault status");

  AST_CMP_FIXED: assert property (
    (spr_req_valid && !spr_req_write && spr_req_num == TLBMA_SPR_CMP)
    |-> s_good_answer ##0 (spr_rdata[31] && !spr_rdata[6]))
    else $error("compare word fixed bits wrong");

  AST_CMP_VIRTUAL_SEGMENT_ID: assert property (
    (spr_req_valid && !spr_req_write && spr_req_num == TLBMA_SPR_CMP)
    |=> (spr_rdata[30:7] == $past(seg_virtual_segment_id)))
    else $error("compare word segment id wrong");

  AST_CMP_API: assert property (
    (spr_req_valid && !spr_req_write && spr_req_num == TLBMA_SPR_CMP)
    |=> (spr_rdata[5:0] == $past(miss_address_reg[27:22])))
    else $error("compare word page index wrong");

  AST_CMP_WRITE_BAD: assert property (
    (spr_req_valid && spr_req_write && spr_req_num == TLBMA_SPR_CMP && !fault_valid)
    |-> s_bad_answer ##0 $stable(miss_address_reg))
    else $error("compare word write not refused");

  AST_HASH_TOP: assert property (
    (spr_req_valid && !spr_req_write
     && (spr_req_num == TLBMA_SPR_HASH_PRI || spr_req_num == TLBMA_SPR_HASH_SEC))
    |=> (spr_rdata[31:25] == $past(table_base_reg[31:25]) && spr_rdata[5:0] == 6'h00))
    else $error("group address origin bits wrong");

  AST_HASH_PAIR: assert property (
    (pri_addr[15:6] ^ sec_addr[15:6]) == 10'h3ff)
    else $error("secondary hash is not the complement of the primary");

  AST_HASH_WRITE_BAD: assert property (
    (spr_req_valid && spr_req_write
     && (spr_req_num == TLBMA_SPR_HASH_PRI || spr_req_num == TLBMA_SPR_HASH_SEC))
    |-> s_bad_answer)
    else $error("group address write not refused");

  AST_FILL_READ_BAD: assert property (
    (spr_req_valid && !spr_req_write
     && (spr_req_num == TLBMA_SPR_FILL_A || spr_req_num == TLBMA_SPR_FILL_B))
    |-> s_bad_answer)
    else $error("fill register read not refused");

  AST_FILL_PAIR: assert property (
    (we_fa && !touch_valid) ##1 (we_fb && set_idx == $past(set_idx))
    |-> (lru_way == $past(lru_way)) ##1 (lk_valid || touch_set != $past(set_idx, 2)
                                        || touch_way != $past(lru_way, 2)
                                        || $past(spr_req_wdata) != $past(spr_req_wdata, 2)))
    else $error("fill pair did not land on one way");

  AST_MRF_RMW: assert property (
    (we_mrf ##1 (rd_ok && sel_mrf && mrf_way == $past(mrf_way) && set_idx == $past(set_idx)
                 && !$past(fault_valid)))
    |=> (spr_rdata == $past(spr_req_wdata, 2)))
    else $error("recent-fault entry write did not read back");

  AST_BAD_NO_WRITE: assert property (
    bad_access |-> !(we_mar || we_miss_status_reg || we_fa || we_fb || we_mrf))
    else $error("invalid access produced a write");
endmodule // tlbma_top

//--- hdl/tlbma_pkg.sv
package tlbma_pkg;
  // ----------------------------------------------------------------
  // Special-register numbers of the miss assist registers
  // ----------------------------------------------------------------
  localparam logic [9:0] TLBMA_SPR_MISS_ADDR = 10'h3a0;
  localparam logic [9:0] TLBMA_SPR_MISS_STAT = 10'h3a1;
  localparam logic [9:0] TLBMA_SPR_CMP = 10'h3a2;
  localparam logic [9:0] TLBMA_SPR_HASH_PRI = 10'h3a3;
  localparam logic [9:0] TLBMA_SPR_HASH_SEC = 10'h3a4;
  localparam logic [9:0] TLBMA_SPR_FILL_A = 10'h3a5;
  localparam logic [9:0] TLBMA_SPR_FILL_B = 10'h3a6;
  localparam logic [9:0] TLBMA_SPR_MRF = 10'h3a7;

  // ----------------------------------------------------------------
  // Reset values, field positions and array geometry
  // ----------------------------------------------------------------
  localparam logic [31:0] TLBMA_MISS_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] TLBMA_MISS_STAT_RST = 32'h0000_0000;
  localparam int TLBMA_SEG_MSB = 31;      // Address bits (0:3) select the segment
  localparam int TLBMA_SEG_LSB = 28;
  localparam int TLBMA_API_MSB = 27;      // Address bits (4:9) form the page index
  localparam int TLBMA_API_LSB = 22;
  localparam int TLBMA_PIDX_MSB = 27;     // Address bits (4:19) feed the hash
  localparam int TLBMA_PIDX_LSB = 12;
  localparam int TLBMA_WAY_MSB = 24;      // Status bits (7:8) name a way
  localparam int TLBMA_WAY_LSB = 23;
  localparam int TLBMA_SET_LSB = 12;
  localparam int TLBMA_SET_BITS = 4;
  localparam int TLBMA_SETS = 16;
  localparam int TLBMA_WAYS = 4;
  localparam logic [2:0] TLBMA_PLRU_RST = 3'h0;

  // Register access state of one special-register request
  typedef enum logic [1:0] {
    TLBMA_ACC_IDLE = 2'b00,
    TLBMA_ACC_OK = 2'b01,
    TLBMA_ACC_BAD = 2'b10
  } tlbma_acc_t;
endpackage

//--- hdl/tlbma_hash.sv
`timescale 1ns/1ps
module tlbma_hash
  import tlbma_pkg::*;
(
  input wire logic [31:0] miss_addr,   // Current miss address
  input wire logic [23:0] seg_virtual_segment_id,    // Segment id of the selected segment
  input wire logic [31:0] table_base,  // Table base register
  output logic [31:0] cmp_word,        // Compare word
  output logic [31:0] pri_addr,        // Primary group address
  output logic [31:0] sec_addr         // Secondary group address
);
  logic [18:0] hash_pri;
  logic [18:0] hash_sec;

  // Group address: origin top bits, masked middle, hash low bits, 64 B groups
  function automatic logic [31:0] tlbma_group(input logic [31:0] base, input logic [18:0] h);
    tlbma_group = {base[31:25], base[24:16] | (h[18:10] & base[8:0]), h[9:0], 6'h00};
  endfunction

  // Valid set, hash select clear, segment id and page index live from inputs
  assign cmp_word = {1'b1, seg_virtual_segment_id, 1'b0, miss_addr[TLBMA_API_MSB:TLBMA_API_LSB]};
  assign hash_pri = seg_virtual_segment_id[18:0] ^ {3'h0, miss_addr[TLBMA_PIDX_MSB:TLBMA_PIDX_LSB]};
  assign hash_sec = ~hash_pri;
  assign pri_addr = tlbma_group(table_base, hash_pri);
  assign sec_addr = tlbma_group(table_base, hash_sec);
endmodule // tlbma_hash

//--- hdl/tlbma_store.sv
`timescale 1ns/1ps
module tlbma_store
  import tlbma_pkg::*;
(
  input wire logic sys_clk,                      // Core clock
  input wire logic rst_n,                        // Synchronous reset, active low
  input wire logic [TLBMA_SET_BITS-1:0] set_idx, // Set from the miss address
  input wire logic fill_we_a,                    // First fill write
  input wire logic fill_we_b,                    // Second fill write
  input wire logic [31:0] fill_data,             // Lower entry word
  input wire logic [30:0] fill_tag,              // Tag from the compare word
  input wire logic [1:0] mrf_way,                // Way for recent-fault access
  input wire logic mrf_we,                       // Recent-fault write
  input wire logic [31:0] mrf_wdata,             // Recent-fault write data
  output logic [31:0] mrf_rdata,                 // Recent-fault read data
  output logic [1:0] lru_way,                    // Least recently used way
  input wire logic touch_valid,                  // Translation hit
  input wire logic [TLBMA_SET_BITS-1:0] touch_set, // Set of the hit
  input wire logic [1:0] touch_way,              // Way of the hit
  output logic lk_valid,                         // Entry valid at touch_set/way
  output logic [30:0] lk_tag,                    // Entry tag
  output logic [31:0] lk_data                    // Entry lower word
);
  logic [31:0] data_a [TLBMA_SETS][TLBMA_WAYS];
  logic [31:0] data_b [TLBMA_SETS][TLBMA_WAYS];
  logic [30:0] tag_mem [TLBMA_SETS][TLBMA_WAYS];
  logic [TLBMA_WAYS-1:0] half_a_reg [TLBMA_SETS];
  logic [TLBMA_WAYS-1:0] half_b_reg [TLBMA_SETS];
  logic [2:0] plru_reg [TLBMA_SETS];

  // Tree pseudo-LRU: bit 0 picks the half, bits 1 and 2 the way in it
  function automatic logic [1:0] tlbma_victim(input logic [2:0] p);
    tlbma_victim = p[0] ? {1'b1, p[2]} : {1'b0, p[1]};
  endfunction
  function automatic logic [2:0] tlbma_touch(input logic [2:0] p, input logic [1:0] w);
    tlbma_touch = w[1] ? {~w[0], p[1], 1'b0} : {p[2], ~w[0], 1'b1};
  endfunction

  assign lru_way = tlbma_victim(plru_reg[set_idx]);
  assign mrf_rdata = data_a[set_idx][mrf_way];
  assign lk_valid = half_a_reg[touch_set][touch_way] && half_b_reg[touch_set][touch_way]
                    && (data_a[touch_set][touch_way] == data_b[touch_set][touch_way]);
  assign lk_tag = tag_mem[touch_set][touch_way];
  assign lk_data = data_a[touch_set][touch_way];

  // Entry words; the second fill lands on the same way as the first one
  always_ff @(posedge sys_clk) begin
    if (fill_we_a) begin
      data_a[set_idx][lru_way] <= fill_data;
      tag_mem[set_idx][lru_way] <= fill_tag;
    end else if (fill_we_b) begin
      data_b[set_idx][lru_way] <= fill_data;
    end else if (mrf_we) begin
      data_a[set_idx][mrf_way] <= mrf_wdata;
      data_b[set_idx][mrf_way] <= mrf_wdata;
    end
  end

  // Half flags and replacement state; the way ages only once both halves are in
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int s = 0; s < TLBMA_SETS; s++) begin
        half_a_reg[s] <= '0;
        half_b_reg[s] <= '0;
        plru_reg[s] <= TLBMA_PLRU_RST;
      end
    end else if (fill_we_a) begin
      half_a_reg[set_idx][lru_way] <= 1'b1;
      half_b_reg[set_idx][lru_way] <= 1'b0;
    end else if (fill_we_b) begin
      half_b_reg[set_idx][lru_way] <= 1'b1;
      if (half_a_reg[set_idx][lru_way])
        plru_reg[set_idx] <= tlbma_touch(plru_reg[set_idx], lru_way);
    end else if (touch_valid) begin
      plru_reg[touch_set] <= tlbma_touch(plru_reg[touch_set], touch_way);
    end
  end
endmodule // tlbma_store

//--- tb/tlbma_top_test.sv
`timescale 1ns/1ps
module tlbma_top_test;
  import tlbma_pkg::*;
  typedef struct {logic wr; logic [9:0] num; logic [31:0] wd; logic [31:0] ex; logic ak; logic il;} tlbma_row_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, spr_req_valid = 1'b0, spr_req_write = 1'b0;
  logic fault_valid = 1'b0, touch_valid = 1'b0, spr_ack, spr_illegal, lk_valid;
  logic [9:0] spr_req_num = 10'h000;
  logic [31:0] spr_req_wdata = 32'h0, fault_ea = 32'h0, fault_status = 32'h0, table_base_reg = 32'h00a4_0003;
  logic [31:0] spr_rdata, lk_data;
  logic [30:0] lk_tag;
  logic [3:0] seg_index, touch_set = 4'h0;
  logic [1:0] touch_way = 2'h0;
  logic [23:0] seg_virtual_segment_id;
  int errors = 0, checks_done = 0;
  tlbma_row_t rows[13];
  // Fill words carry the referenced bit, as the handler also sets it in the table
  localparam logic [31:0] MA = 32'h5ab3_7000, EA = 32'h9c4d_5000, D = 32'h1234_5112, D2 = 32'h0abc_d112;
  // Segment file stand-in: id depends on the selector so a wrong selector shows
  function automatic logic [23:0] virtual_segment_id_of(logic [3:0] s);
    return {s, 20'h3c5a1};
  endfunction
  function automatic logic [31:0] cmp_of(logic [31:0] m);
    return {1'b1, virtual_segment_id_of(m[31:28]), 1'b0, m[27:22]};
  endfunction
  function automatic logic [31:0] grp_of(logic [31:0] m, logic [31:0] b, logic sec);
    logic [23:0] v;
    logic [18:0] h;
    v = virtual_segment_id_of(m[31:28]);
    h = v[18:0] ^ {3'h0, m[27:12]};
    if (sec) h = ~h;
    return {b[31:25], b[24:16] | (h[18:10] & b[8:0]), h[9:0], 6'h00};
  endfunction
  assign seg_virtual_segment_id = virtual_segment_id_of(seg_index);
  always #50 sys_clk = ~sys_clk;
  tlbma_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .spr_req_valid(spr_req_valid), .spr_req_write(spr_req_write),
    .spr_req_num(spr_req_num), .spr_req_wdata(spr_req_wdata), .spr_ack(spr_ack), .spr_rdata(spr_rdata),
    .spr_illegal(spr_illegal), .fault_valid(fault_valid), .fault_ea(fault_ea), .fault_status(fault_status),
    .seg_index(seg_index), .seg_virtual_segment_id(seg_virtual_segment_id), .table_base_reg(table_base_reg), .touch_valid(touch_valid),
    .touch_set(touch_set), .touch_way(touch_way), .lk_valid(lk_valid), .lk_tag(lk_tag), .lk_data(lk_data));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One move, driven at the falling edge; the answer is read a cycle later.
  // With keep set, valid stays up so the next call follows back to back.
  task automatic xfer(input logic wr, input logic [9:0] num, input logic [31:0] wd, input logic [31:0] ex,
                      input logic ak, input logic il, input bit keep = 1'b0);
    if (!spr_req_valid) @(negedge sys_clk);
    {spr_req_valid, spr_req_write, spr_req_num, spr_req_wdata} = {1'b1, wr, num, wd};
    @(negedge sys_clk);
    if (!keep) spr_req_valid = 1'b0;
    chk($sformatf("ack %h", num), {31'h0, ak}, {31'h0, spr_ack});
    chk($sformatf("illegal %h", num), {31'h0, il}, {31'h0, spr_illegal});
    chk($sformatf("rdata %h", num), ex, spr_rdata);
  endtask
  task automatic close_out();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog: the whole run needs about 65 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{1, TLBMA_SPR_MISS_ADDR, MA, 0, 1, 0}, '{0, TLBMA_SPR_MISS_ADDR, 0, MA, 1, 0},
      '{1, TLBMA_SPR_MISS_STAT, 32'h0180_0000, 0, 1, 0}, '{0, TLBMA_SPR_MISS_STAT, 0, 32'h0180_0000, 1, 0},
      '{0, TLBMA_SPR_CMP, 0, cmp_of(MA), 1, 0}, '{0, TLBMA_SPR_HASH_PRI, 0, grp_of(MA, table_base_reg, 0), 1, 0},
      '{0, TLBMA_SPR_HASH_SEC, 0, grp_of(MA, table_base_reg, 1), 1, 0}, '{1, TLBMA_SPR_CMP, 32'hffff_ffff, 0, 1, 1},
      '{1, TLBMA_SPR_HASH_PRI, 32'h1, 0, 1, 1}, '{1, TLBMA_SPR_HASH_SEC, 32'h1, 0, 1, 1},
      '{0, TLBMA_SPR_FILL_A, 0, 0, 1, 1}, '{0, TLBMA_SPR_FILL_B, 0, 0, 1, 1}, '{0, 10'h3a8, 0, 0, 0, 0}};
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    foreach (rows[i]) xfer(rows[i].wr, rows[i].num, rows[i].wd, rows[i].ex, rows[i].ak, rows[i].il);
    xfer(0, TLBMA_SPR_CMP, 0, cmp_of(MA), 1, 0);
    // Second reset in mid-run clears the captured values
    @(negedge sys_clk) rst_n = 1'b0;
    @(negedge sys_clk) rst_n = 1'b1;
    xfer(0, TLBMA_SPR_MISS_ADDR, 0, 32'h0, 1, 0);
    // Write then read back to back
    xfer(1, TLBMA_SPR_MISS_ADDR, MA, 0, 1, 0, 1);
    xfer(0, TLBMA_SPR_MISS_ADDR, 0, MA, 1, 0);
    // Fault capture; status way bits left at zero for the recent-fault access
    @(negedge sys_clk) {fault_valid, fault_ea, fault_status} = {1'b1, EA, 32'h0200_0000};
    @(negedge sys_clk) fault_valid = 1'b0;
    xfer(0, TLBMA_SPR_MISS_ADDR, 0, EA, 1, 0);
    xfer(0, TLBMA_SPR_MISS_STAT, 0, 32'h0200_0000, 1, 0);
    table_base_reg = 32'h0e00_01ff;
    xfer(0, TLBMA_SPR_HASH_PRI, 0, grp_of(EA, 32'h0e00_01ff, 0), 1, 0);
    // Fill both halves; reset left the victim at way 0
    xfer(1, TLBMA_SPR_FILL_A, D, 0, 1, 0, 1);
    xfer(1, TLBMA_SPR_FILL_B, D, 0, 1, 0);
    touch_set = EA[15:12];
    #1 chk("entry valid", 32'h1, {31'h0, lk_valid});
    chk("entry data", D, lk_data);
    chk("entry tag", {1'b0, 1'b1, virtual_segment_id_of(EA[31:28]), EA[27:22]}, {1'b0, lk_tag});
    xfer(0, TLBMA_SPR_MRF, 0, D, 1, 0);
    xfer(1, TLBMA_SPR_MRF, D | 32'h80, 0, 1, 0, 1);
    xfer(0, TLBMA_SPR_MRF, 0, D | 32'h80, 1, 0);
    // Tree ages way 0, so the next pair lands on way 2; a hit on way 1 then moves the victim to way 3
    xfer(1, TLBMA_SPR_FILL_A, D2, 0, 1, 0, 1);
    xfer(1, TLBMA_SPR_FILL_B, D2, 0, 1, 0);
    touch_way = 2'h2;
    #1 chk("way 2 data", D2, lk_data);
    chk("way 2 valid", 32'h1, {31'h0, lk_valid});
    @(negedge sys_clk) {touch_valid, touch_way} = {1'b1, 2'h1};
    @(negedge sys_clk) touch_valid = 1'b0;
    xfer(1, TLBMA_SPR_FILL_A, D, 0, 1, 0, 1);
    xfer(1, TLBMA_SPR_FILL_B, D, 0, 1, 0);
    touch_way = 2'h3;
    #1 chk("way 3 data", D, lk_data);
    chk("way 3 valid", 32'h1, {31'h0, lk_valid});
    close_out();
  end
endmodule // tlbma_top_test
